// ---- rtl/ddb_pkg.sv ----
// ddb_pkg: constants, pin encodings and carrier types of the DDR3 burst data path controller.
// assumes one byte lane, a 40 MHz ref_clk, and a memory clock made by dividing ref_clk by four.
// Functional notes
// - BL8 when field 00, or 01 with A12
// - accepted write burst never interrupted
// - write latency equals AL plus CWL
// - controller drives full-cycle write preamble
// - controller drives half-cycle write postamble
// - first write strobe edge WL clocks after command
// - mask high suppresses that write element
// - write-to-write concatenation after column spacing
// - read only after write-to-read delay
// - precharge only after write recovery time
// - delay start points follow burst setting
// - read latency equals AL plus CL
// - on-the-fly field 01, A12 low chops
// - field 10 chops every burst to four
package ddb_pkg;

    localparam int unsigned DQ_W            = 8;
    localparam int unsigned DATA_W          = 64;
    localparam int unsigned Q_DEPTH         = 8;
    localparam int unsigned SYNC_W          = DQ_W + 2;

    // memory clock is ref_clk divided by four: phases 0,1 high and 2,3 low
    localparam int unsigned REF_CLK_PERIOD_NS = 25;
    localparam int unsigned CK_DIV            = 4;
    localparam int unsigned CK_PERIOD_NS      = REF_CLK_PERIOD_NS * CK_DIV;
    // write strobe placed on the memory clock edges, nominal skew
    localparam int unsigned WRITE_STROBE_SKEW_NS = 0;

    localparam logic [1:0] PH_RISE = 2'h0;
    localparam logic [1:0] PH_Q1   = 2'h1;
    localparam logic [1:0] PH_FALL = 2'h2;
    localparam logic [1:0] PH_Q3   = 2'h3;

    localparam logic [1:0] BURST_BL8_FIXED = 2'h0;
    localparam logic [1:0] BURST_OTF       = 2'h1;
    localparam logic [1:0] BURST_BC4_FIXED = 2'h2;

    localparam logic [15:0] COLUMN_COMMAND_SPACING = 16'h0004;
    localparam logic [15:0] BL8_DATA_CYC           = 16'h0004;
    localparam logic [15:0] BC4_DATA_CYC           = 16'h0002;
    localparam logic [15:0] READ_TO_WRITE_EXTRA    = 16'h0001;
    localparam logic [2:0]  LAST_BEAT_BL8          = 3'h7;
    localparam logic [2:0]  LAST_BEAT_BC4          = 3'h3;
    localparam logic [3:0]  Q_FULL                 = 4'h8;

    localparam int unsigned A10_BIT = 10;
    localparam int unsigned A12_BIT = 12;

    // {ras_n, cas_n, we_n}
    localparam logic [2:0] OP_NOP   = 3'h7;
    localparam logic [2:0] OP_READ  = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_PRE   = 3'h2;

    typedef enum logic [1:0] {DDB_NOP, DDB_READ, DDB_WRITE, DDB_PRE} ddb_kind_e;
    typedef enum logic [1:0] {WR_IDLE, WR_PRE, WR_DATA, WR_POST} ddb_wr_state_e;

    typedef struct packed {
        ddb_kind_e   kind;
        logic [2:0]  bank;
        logic [9:0]  col;
        logic        auto_pre;
        logic        bl8_sel;
        logic        all_banks;
    } ddb_req_s;

    typedef struct packed {
        logic [1:0]  burst_mode;
        logic [4:0]  al;
        logic [4:0]  cwl;
        logic [4:0]  cl;
        logic [4:0]  wtr_cyc;
        logic [4:0]  wr_cyc;
        logic        odt;
    } ddb_cfg_s;

    typedef struct packed {
        logic        cs_n;
        logic [2:0]  op;
        logic [2:0]  ba;
        logic [14:0] addr;
    } ddb_cmd_pins_s;

    typedef struct packed {
        logic [15:0]       start;
        logic              bc4;
        logic [DATA_W-1:0] data;
        logic [7:0]        mask;
    } ddb_slot_s;

    localparam ddb_cmd_pins_s PINS_IDLE = '{cs_n: 1'h0, op: OP_NOP, ba: 3'h0, addr: 15'h0000};

endpackage

// ---- rtl/ddb_clk_div.sv ----
// ddb_clk_div: makes the memory clock pair from ref_clk, plus the phase and memory-cycle count.
// assumes ref_clk is the only clock; the memory clock is an ordinary registered output.
`timescale 1ns/10ps
module ddb_clk_div
    import ddb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    output logic [1:0]       phase,
    output logic [15:0]      cyc,
    output logic             ck,
    output logic             ck_n
);

    logic [1:0] next_phase;

    assign next_phase = phase + 2'h1;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_RISE;
            cyc   <= 16'h0000;
            ck    <= 1'h1;
            ck_n  <= 1'h0;
        end else begin
            phase <= next_phase;
            if (phase == PH_Q3) begin
                cyc <= cyc + 16'h0001;
            end
            ck   <= (next_phase == PH_RISE) || (next_phase == PH_Q1);
            ck_n <= !((next_phase == PH_RISE) || (next_phase == PH_Q1));
        end
    end

endmodule // ddb_clk_div

// ---- rtl/ddb_pin_sync.sv ----
// ddb_pin_sync: three-stage synchroniser per bit; output follows once stages two and three agree.
// assumes inputs are asynchronous pins; output is on ref_clk.
`timescale 1ns/10ps
module ddb_pin_sync
    import ddb_pkg::*;
#(
    parameter int unsigned W = SYNC_W
)
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                s1[i]   <= 1'h0;
                s2[i]   <= 1'h0;
                s3[i]   <= 1'h0;
                dout[i] <= 1'h0;
            end else begin
                s1[i] <= din[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end

endmodule // ddb_pin_sync

// ---- rtl/ddb_host.sv ----
// ddb_host: controller side of one DDR3 byte lane: issues read, write and precharge commands,
// launches write bursts with strobe preamble/postamble and collects read bursts.
// assumes the user holds cmd and write data stable while cmd_valid is high until taken.
`timescale 1ns/10ps
module ddb_host
    import ddb_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire ddb_cfg_s          cfg,
    input  wire logic              cmd_valid,
    input  wire ddb_req_s          cmd,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [7:0]        wr_mask,
    output logic                   cmd_ready,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   ck,
    output logic                   ck_n,
    output ddb_cmd_pins_s          pins,
    output logic                   odt,
    output logic [DQ_W-1:0]        dq_o,
    output logic                   dq_oe,
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic                   dm,
    output logic                   dm_oe,
    output logic                   dqs_o,
    output logic                   dqs_oe,
    input  wire logic              dqs_i,
    output logic                   dqs_n_o,
    output logic                   dqs_n_oe,
    input  wire logic              dqs_n_i
);

    logic [1:0]        phase;
    logic [15:0]       cyc;
    logic [1:0]        np;
    logic [15:0]       nc;
    logic [15:0]       cc;
    logic [15:0]       wl;
    logic [15:0]       rl;
    logic [15:0]       data_span;
    logic              bc4_req;
    logic              allowed;
    logic              take;
    ddb_cmd_pins_s     next_pins;
    logic [15:0]       col_at;
    logic [15:0]       rd_at;
    logic [15:0]       wr_at;
    logic [15:0]       pre_at;

    ddb_slot_s         wq [Q_DEPTH];
    logic [2:0]        wq_wp;
    logic [2:0]        wq_rp;
    logic [3:0]        wq_cnt;
    ddb_slot_s         head;
    logic              head_hit;
    logic              wr_pop;
    ddb_wr_state_e     w_state;
    logic [2:0]        w_beat;
    logic [2:0]        w_next_beat;
    logic [2:0]        w_last;

    logic [15:0]       rq_start [Q_DEPTH];
    logic              rq_bc4   [Q_DEPTH];
    logic [2:0]        rq_wp;
    logic [2:0]        rq_rp;
    logic [3:0]        rq_cnt;
    logic              rd_pop;
    logic [SYNC_W-1:0] rsync;
    logic              prev_dqs;
    logic              edge_ok;
    logic              armed;
    logic [2:0]        r_beat;
    logic [2:0]        r_last;
    logic [DATA_W-1:0] rd_buf;
    logic [DATA_W-1:0] next_rd_buf;

    function automatic logic reached(input logic [15:0] now, input logic [15:0] at);
        logic [15:0] d;
        d = now - at;
        return !d[15];
    endfunction

    ddb_clk_div u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .phase   (phase),
        .cyc     (cyc),
        .ck      (ck),
        .ck_n    (ck_n)
    );

    ddb_pin_sync #(.W(SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     ({dqs_n_i, dqs_i, dq_i}),
        .dout    (rsync)
    );

    // np/nc name the phase and memory cycle that a register update becomes visible in
    assign np = phase + 2'h1;
    assign nc = (phase == PH_Q3) ? cyc + 16'h0001 : cyc;
    // a command taken in phase 1 is registered by the device at the next rising edge
    assign cc = cyc + 16'h0001;
    assign wl = 16'(cfg.al) + 16'(cfg.cwl);
    assign rl = 16'(cfg.al) + 16'(cfg.cl);
    assign bc4_req = (cfg.burst_mode == BURST_BC4_FIXED) ||
                     ((cfg.burst_mode == BURST_OTF) && !cmd.bl8_sel);
    // only a fixed chop setting lets the delays start after two data cycles
    assign data_span = (cfg.burst_mode == BURST_BC4_FIXED) ? BC4_DATA_CYC : BL8_DATA_CYC;
    assign take = cmd_valid && cmd_ready && (phase == PH_Q1);

    always_comb begin
        case (cmd.kind)
            DDB_READ:  allowed = reached(cc, col_at) && reached(cc, rd_at) && (rq_cnt != Q_FULL);
            DDB_WRITE: allowed = reached(cc, col_at) && reached(cc, wr_at) && (wq_cnt != Q_FULL);
            DDB_PRE:   allowed = reached(cc, pre_at);
            default:   allowed = 1'h0;
        endcase
    end

    // ready is a one-cycle window in phase 1 that only opens for a legal command
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ready <= 1'h0;
        end else begin
            cmd_ready <= (np == PH_Q1) && cmd_valid && allowed && !take;
        end
    end

    always_comb begin
        next_pins                = PINS_IDLE;
        next_pins.ba             = cmd.bank;
        next_pins.addr[9:0]      = cmd.col;
        next_pins.addr[A12_BIT]  = cmd.bl8_sel;
        case (cmd.kind)
            DDB_READ: begin
                next_pins.op            = OP_READ;
                next_pins.addr[A10_BIT] = cmd.auto_pre;
            end
            DDB_WRITE: begin
                next_pins.op            = OP_WRITE;
                next_pins.addr[A10_BIT] = cmd.auto_pre;
            end
            DDB_PRE: begin
                next_pins.op            = OP_PRE;
                next_pins.addr[A10_BIT] = cmd.all_banks;
            end
            default: begin
                next_pins.op            = OP_NOP;
            end
        endcase
    end

    // command pins change in the low half so they are steady across the rising edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins <= PINS_IDLE;
            odt  <= 1'h0;
        end else begin
            odt <= cfg.odt;
            if (take) begin
                pins <= next_pins;
            end else if (phase == PH_Q1) begin
                pins <= PINS_IDLE;
            end
        end
    end

    // spacing deadlines, kept as the first memory cycle a command may land on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_at <= 16'h0000;
            rd_at  <= 16'h0000;
            wr_at  <= 16'h0000;
            pre_at <= 16'h0000;
        end else if (take) begin
            if (cmd.kind == DDB_READ || cmd.kind == DDB_WRITE) begin
                col_at <= cc + COLUMN_COMMAND_SPACING;
            end
            if (cmd.kind == DDB_WRITE) begin
                rd_at  <= cc + wl + data_span + 16'(cfg.wtr_cyc);
                pre_at <= cc + wl + data_span + 16'(cfg.wr_cyc);
            end
            if (cmd.kind == DDB_READ) begin
                wr_at <= cc + rl + COLUMN_COMMAND_SPACING + READ_TO_WRITE_EXTRA - wl;
            end
        end
    end

    // pending write bursts; several can wait while write latency runs
    always_ff @(posedge ref_clk) begin
        if (take && cmd.kind == DDB_WRITE) begin
            wq[wq_wp] <= '{start: cc + wl, bc4: bc4_req, data: wr_data, mask: wr_mask};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wq_wp  <= 3'h0;
            wq_rp  <= 3'h0;
            wq_cnt <= 4'h0;
        end else begin
            if (take && cmd.kind == DDB_WRITE) begin
                wq_wp <= wq_wp + 3'h1;
            end
            if (wr_pop) begin
                wq_rp <= wq_rp + 3'h1;
            end
            wq_cnt <= wq_cnt + {3'h0, take && cmd.kind == DDB_WRITE} - {3'h0, wr_pop};
        end
    end

    assign head        = wq[wq_rp];
    assign head_hit    = (wq_cnt != 4'h0) && (head.start == nc + 16'h0001);
    assign w_last      = head.bc4 ? LAST_BEAT_BC4 : LAST_BEAT_BL8;
    assign w_next_beat = w_beat + 3'h1;
    // pop on the last strobe fall so the next burst is at the head one edge later
    assign wr_pop      = (w_state == WR_DATA) && (np == PH_FALL) && (w_beat == w_last);

    // write burst engine: strobe toggles on memory clock edges, data moves a quarter earlier
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_state  <= WR_IDLE;
            w_beat   <= 3'h0;
            dqs_o    <= 1'h0;
            dqs_n_o  <= 1'h0;
            dqs_oe   <= 1'h0;
            dqs_n_oe <= 1'h0;
            dq_o     <= 8'h00;
            dq_oe    <= 1'h0;
            dm       <= 1'h0;
            dm_oe    <= 1'h0;
        end else begin
            case (w_state)
                WR_IDLE: begin
                    if (np == PH_RISE && head_hit) begin
                        w_state  <= WR_PRE;
                        dqs_oe   <= 1'h1;
                        dqs_n_oe <= 1'h1;
                        dqs_o    <= 1'h1;
                        dqs_n_o  <= 1'h0;
                    end
                end
                WR_PRE: begin
                    if (np == PH_FALL) begin
                        dqs_o   <= 1'h0;
                        dqs_n_o <= 1'h1;
                    end else if (np == PH_Q3) begin
                        w_state <= WR_DATA;
                        w_beat  <= 3'h0;
                        dq_oe   <= 1'h1;
                        dm_oe   <= 1'h1;
                        dq_o    <= head.data[7:0];
                        dm      <= head.mask[0];
                    end
                end
                WR_DATA: begin
                    if (np == PH_RISE) begin
                        dqs_o   <= 1'h1;
                        dqs_n_o <= 1'h0;
                    end else if (np == PH_FALL) begin
                        dqs_o   <= 1'h0;
                        dqs_n_o <= 1'h1;
                        if (w_beat == w_last) begin
                            w_state <= WR_POST;
                        end
                    end else begin
                        w_beat <= w_next_beat;
                        dq_o   <= head.data[{w_next_beat, 3'h0} +: 8];
                        dm     <= head.mask[w_next_beat];
                    end
                end
                WR_POST: begin
                    if (np == PH_Q3) begin
                        if (head_hit) begin
                            w_state <= WR_DATA;
                            w_beat  <= 3'h0;
                            dq_o    <= head.data[7:0];
                            dm      <= head.mask[0];
                        end else begin
                            dq_oe <= 1'h0;
                            dm_oe <= 1'h0;
                        end
                    end else if (np == PH_RISE) begin
                        if (head_hit) begin
                            w_state <= WR_PRE;
                            dqs_o   <= 1'h1;
                            dqs_n_o <= 1'h0;
                        end else begin
                            w_state  <= WR_IDLE;
                            dqs_oe   <= 1'h0;
                            dqs_n_oe <= 1'h0;
                        end
                    end
                end
                default: begin
                    w_state <= WR_IDLE;
                end
            endcase
        end
    end

    // expected read bursts, opened one memory cycle before their read latency
    always_ff @(posedge ref_clk) begin
        if (take && cmd.kind == DDB_READ) begin
            rq_start[rq_wp] <= cc + rl;
            rq_bc4[rq_wp]   <= bc4_req;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rq_wp  <= 3'h0;
            rq_rp  <= 3'h0;
            rq_cnt <= 4'h0;
        end else begin
            if (take && cmd.kind == DDB_READ) begin
                rq_wp <= rq_wp + 3'h1;
            end
            if (rd_pop) begin
                rq_rp <= rq_rp + 3'h1;
            end
            rq_cnt <= rq_cnt + {3'h0, take && cmd.kind == DDB_READ} - {3'h0, rd_pop};
        end
    end

    // a strobe edge counts only while the pair is complementary, so a floating pair is ignored
    assign edge_ok = (rsync[DQ_W] != prev_dqs) && (rsync[DQ_W] != rsync[DQ_W+1]);
    assign armed   = (rq_cnt != 4'h0) && reached(cyc, rq_start[rq_rp] - 16'h0001);
    assign r_last  = rq_bc4[rq_rp] ? LAST_BEAT_BC4 : LAST_BEAT_BL8;

    always_comb begin
        next_rd_buf = rd_buf;
        next_rd_buf[{r_beat, 3'h0} +: 8] = rsync[DQ_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_dqs <= 1'h0;
        end else if (rsync[DQ_W] != rsync[DQ_W+1]) begin
            prev_dqs <= rsync[DQ_W];
        end
    end

    // read collector: first beat must be a rising edge out of the low preamble
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_beat   <= 3'h0;
            rd_buf   <= 64'h0000_0000_0000_0000;
            rd_valid <= 1'h0;
            rd_data  <= 64'h0000_0000_0000_0000;
            rd_pop   <= 1'h0;
        end else begin
            rd_valid <= 1'h0;
            rd_pop   <= 1'h0;
            if (armed && edge_ok && !rd_pop && (r_beat != 3'h0 || rsync[DQ_W])) begin
                if (r_beat == r_last) begin
                    rd_valid <= 1'h1;
                    rd_data  <= next_rd_buf;
                    rd_buf   <= 64'h0000_0000_0000_0000;
                    rd_pop   <= 1'h1;
                    r_beat   <= 3'h0;
                end else begin
                    rd_buf <= next_rd_buf;
                    r_beat <= r_beat + 3'h1;
                end
            end
        end
    end

endmodule // ddb_host

// ---- bench/ddb_host_properties.sv ----
// ddb_host_properties: pin timing checks for the controller.
// assumes the write latency check fires only when al plus cwl is 5.
`timescale 1ns/10ps
module ddb_host_properties
    import ddb_pkg::*;
(
    input wire logic     ref_clk,
    input wire logic     rst_n,
    input wire ddb_cfg_s cfg,
    input wire logic     cmd_valid,
    input wire ddb_req_s cmd,
    input wire logic     cmd_ready,
    input wire logic     dq_oe,
    input wire logic     dm_oe,
    input wire logic     dqs_o,
    input wire logic     dqs_oe,
    input wire logic     dqs_n_o,
    input wire logic     dqs_n_oe
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic take_rw;
    assign take = cmd_valid && cmd_ready;
    assign take_rw = take && cmd.kind inside {DDB_READ, DDB_WRITE};

    a_strobe_oe_pair: assert property (dqs_oe == dqs_n_oe) else $error("strobe oe split");
    a_strobe_compl: assert property (dqs_oe |-> dqs_o != dqs_n_o) else $error("strobe pair");
    a_mask_with_data: assert property (dq_oe == dm_oe) else $error("mask oe");
    a_write_preamble: assert property ($rose(dqs_oe) |-> dqs_o ##1 dqs_o ##1 !dqs_o ##1 (!dqs_o && dq_oe))
        else $error("preamble");
    a_write_postamble: assert property ($fell(dq_oe) |-> dqs_oe && !dqs_o ##1 (dqs_oe == dqs_o))
        else $error("postamble");
    a_write_latency: assert property (take && cmd.kind == DDB_WRITE && cfg.al + cfg.cwl == 5'h05
        |-> ##19 (dqs_oe && dqs_o) ##3 dq_oe) else $error("write latency");
    a_cmd_spacing: assert property (take_rw |-> ##4 !take_rw ##4 !take_rw ##4 !take_rw)
        else $error("column spacing");
    a_bc4_span: assert property ($rose(dq_oe) && cfg.burst_mode == BURST_BC4_FIXED
        |-> dq_oe [*8] ##1 !dq_oe) else $error("chop span");
    c_write: cover property (take && cmd.kind == DDB_WRITE);
    c_read: cover property (take && cmd.kind == DDB_READ);
    c_post: cover property ($fell(dqs_oe));
endmodule // ddb_host_properties

bind ddb_host ddb_host_properties ddb_host_properties_inst (.ref_clk, .rst_n, .cfg, .cmd_valid, .cmd,
    .cmd_ready, .dq_oe, .dm_oe, .dqs_o, .dqs_oe, .dqs_n_o, .dqs_n_oe);

// ---- bench/ddb_dev_model.sv ----
// ddb_dev_model: behavioural memory lane answering the controller.
// assumes aligned burst columns and one read in flight at a time.
`timescale 1ns/10ps
module ddb_dev_model
    import ddb_pkg::*;
(
    input  wire ddb_cfg_s        cfg,
    input  wire logic            ck,
    input  wire ddb_cmd_pins_s   pins,
    input  wire logic [DQ_W-1:0] dq_o,
    input  wire logic            dq_oe,
    input  wire logic            dm,
    input  wire logic            dqs_o,
    input  wire logic            dqs_oe,
    input  wire logic            dqs_n_o,
    output logic [DQ_W-1:0]      dq_i,
    output logic                 dqs_i,
    output logic                 dqs_n_i
);
    logic [7:0]      mem [int];
    logic [DQ_W-1:0] m_dq = 8'h00;
    logic            m_s = 1'b1;
    logic            m_n = 1'b1;
    // terminated idle strobes read as an equal pair
    assign dqs_i = dqs_oe ? dqs_o : m_s;
    assign dqs_n_i = dqs_oe ? dqs_n_o : m_n;
    assign dq_i = dq_oe ? dq_o : m_dq;

    function automatic int blen(input logic a12);
        return (cfg.burst_mode == BURST_OTF ? a12 : cfg.burst_mode != BURST_BC4_FIXED) ? 8 : 4;
    endfunction

    task automatic wr(input ddb_cmd_pins_s p);
        int n;
        n = blen(p.addr[A12_BIT]);
        repeat (cfg.al + cfg.cwl - 1) @(posedge ck);
        @(negedge dqs_o);
        for (int k = 0; k < n; k++) begin
            @(dqs_o);
            if (!dm) mem[{p.ba, p.addr[9:3], k[2:0]}] = dq_o;
        end
    endtask

    task automatic rd(input ddb_cmd_pins_s p);
        int n;
        n = blen(p.addr[A12_BIT]);
        repeat (cfg.al + cfg.cl - 1) @(posedge ck);
        #2 {m_s, m_n} = 2'h1;
        for (int k = 0; k < n; k++) begin
            if (k[0])
                @(negedge ck);
            else
                @(posedge ck);
            #2 m_dq = mem[{p.ba, p.addr[9:3], k[2:0]}];
            {m_s, m_n} = {~k[0], k[0]};
        end
        @(posedge ck);
        #2 {m_s, m_n} = 2'h3;
        m_dq = ~m_dq;
    endtask

    always @(posedge ck) begin
        if (pins.op == OP_WRITE)
            fork wr(pins); join_none
        if (pins.op == OP_READ)
            fork rd(pins); join_none
    end
endmodule // ddb_dev_model

// ---- bench/test_ddr3_burst_data_path.sv ----
// test_ddr3_burst_data_path: self-checking bench for ddb_host.
// assumes ddb_dev_model as the memory; write and read latency are 5.
`timescale 1ns/10ps
module test_ddr3_burst_data_path;
    import ddb_pkg::*;
    logic              ref_clk, rst_n, cmd_valid, cmd_ready, rd_valid, ck;
    logic              dq_oe, dm, dqs_o, dqs_oe, dqs_n_o, dqs_i, dqs_n_i, odt;
    logic [DQ_W-1:0]   dq_o, dq_i;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [7:0]        wr_mask;
    ddb_cfg_s          cfg;
    ddb_req_s          cmd;
    ddb_cmd_pins_s     pins;
    int                n_fail, compares;
    time               t_take, tw;

    ddb_host ddb_host_inst (.ref_clk, .rst_n, .cfg, .cmd_valid, .cmd, .wr_data, .wr_mask, .cmd_ready, .rd_valid,
        .rd_data, .ck, .ck_n(), .pins, .odt, .dq_o, .dq_oe, .dq_i, .dm, .dm_oe(), .dqs_o, .dqs_oe, .dqs_i,
        .dqs_n_o, .dqs_n_oe(), .dqs_n_i);
    ddb_dev_model ddb_dev_model_inst (.cfg, .ck, .pins, .dq_o, .dq_oe, .dm, .dqs_o, .dqs_oe, .dqs_n_o, .dq_i,
        .dqs_i, .dqs_n_i);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #500us;
        n_fail++;
        summarize();
    end

    task automatic summarize;
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic issue(input ddb_kind_e k, input logic [9:0] col, input logic a12, input logic [63:0] d,
        input logic [7:0] m);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{kind: k, bank: 3'h2, col: col, auto_pre: a12, bl8_sel: a12, all_banks: 1'b0};
        wr_data <= d;
        wr_mask <= m;
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        t_take = $time;
    endtask

    task automatic rdchk(input logic [9:0] col, input logic a12, input logic [63:0] e);
        issue(DDB_READ, col, a12, 64'h0, 8'h00);
        cmd_valid <= 1'b0;
        @(posedge ref_clk iff rd_valid === 1'b1);
        chk(e, rd_data);
    endtask

    // memory cycles between the last two takes, one cycle of slack
    task automatic gap(input int e);
        int m;
        m = int'((t_take - tw) / 100);
        chk(64'h1, 64'(m >= e && m <= e + 1));
    endtask

    task automatic sc_concat;
        issue(DDB_WRITE, 10'h008, 1'b1, 64'h8877665544332211, 8'h00);
        tw = t_take;
        issue(DDB_WRITE, 10'h008, 1'b1, 64'hF0E0D0C0B0A09080, 8'h5A);
        cmd_valid <= 1'b0;
        chk(64'h10, 64'((t_take - tw) / 25));
        rdchk(10'h008, 1'b1, 64'hF077D05544A02280);
    endtask

    task automatic sc_turn(input logic [1:0] mode, input logic a12, input logic [7:0] s);
        logic [63:0] d;
        logic        bl8;
        d = 64'h0123456789ABCDEF ^ {8{s}};
        bl8 = mode == BURST_BL8_FIXED || (mode == BURST_OTF && a12);
        cfg.burst_mode <= mode;
        issue(DDB_WRITE, 10'h010, a12, d, 8'h00);
        tw = t_take;
        rdchk(10'h010, a12, bl8 ? d : {32'h0, d[31:0]});
        gap(mode == BURST_BC4_FIXED ? 9 : 11);
    endtask

    task automatic sc_pre;
        cfg.burst_mode <= BURST_BL8_FIXED;
        issue(DDB_WRITE, 10'h018, 1'b1, 64'h0, 8'h00);
        tw = t_take;
        issue(DDB_PRE, 10'h000, 1'b0, 64'h0, 8'h00);
        cmd_valid <= 1'b0;
        gap(12);
        chk(64'(cfg.odt), 64'(odt));
    endtask

    initial begin
        cfg = '{burst_mode: BURST_BL8_FIXED, al: 5'h00, cwl: 5'h05, cl: 5'h05, wtr_cyc: 5'h02, wr_cyc: 5'h03,
            odt: 1'b1};
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        wr_data = '0;
        wr_mask = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        sc_concat();
        sc_turn(BURST_BL8_FIXED, 1'b0, 8'h01);
        sc_turn(BURST_OTF, 1'b0, 8'h02);
        sc_turn(BURST_OTF, 1'b1, 8'h03);
        sc_turn(BURST_BC4_FIXED, 1'b0, 8'h04);
        sc_pre();
        summarize();
    end
endmodule // test_ddr3_burst_data_path
